// ### dv/exec_unit_tb.sv
// Self-checking bench for the execution unit
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module exec_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic clock, arst_n, ivalid, tsave, irq, nmi, psel, penable, pwrite, err;
  logic iready, itake, inmi, dbg, mreq, mack, pready, pslverr, unk;
  logic [7:0] paddr;
  logic [2:0] lat;
  word_t instr, pwdata, pc, iret, maddr, mrdata, prdata, rd, tc_pc, pc_e;
  psw_t psw_e, tc_psw;
  word_t regs [0:31];
  int fail_count, checks_done;
  localparam word_t INIT [0:11] = '{32'h80000000, 32'hFFFFFFFF, 32'h0, 32'h7, 32'hFFFFFFFE,
    32'h80000000, 32'h64, 32'h11, 32'h12345678, 32'h3, 32'hA, 32'hA};

  exec_unit dut (.CLOCK(clock), .ARST_N(arst_n), .CE(1'h1), .INSTR(instr),
    .INSTR_VALID(ivalid), .INSTR_READY(iready), .INSTR_UNKNOWN(unk), .TCALL_SAVE(tsave),
    .IRQ_REQ(irq), .NMI_REQ(nmi), .INT_TAKE(itake), .INT_NMI(inmi), .INT_RET_PC(iret),
    .DEBUG_MODE(dbg), .PC(pc), .MEM_REQ(mreq), .MEM_ADDR(maddr), .MEM_RDATA(mrdata),
    .MEM_ACK(mack), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  stack_mem_model mem (.clk(clock), .arst_n(arst_n), .req(mreq), .addr(maddr), .lat(lat),
    .rdata(mrdata), .ack(mack));

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input word_t d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // Completion and read data are taken only at the edge that sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask

  task automatic chk_reg(input logic [7:0] a, input word_t e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic chk_gpr(input logic [4:0] n);
    chk_reg({1'h1, n, 2'h0}, regs[n]);
  endtask

  task automatic chk_pc();
    @(negedge clock);
    `CHK(pc, pc_e)
    @(posedge clock);
  endtask

  task automatic wait_ready();
    logic ok;
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clock);
      ok = (iready === 1'h1);
      @(posedge clock);
    end
  endtask

  task automatic issue(input word_t w, input logic fin);
    instr <= w;
    ivalid <= 1'h1;
    wait_ready();
    ivalid <= 1'h0;
    if (fin) wait_ready();
  endtask

  task automatic wait_take(input logic n);
    logic got;
    got = 1'h0;
    for (int i = 0; i < 12 && !got; i++) begin
      @(negedge clock);
      got = (itake === 1'h1);
      @(posedge clock);
    end
    `CHK(got, 1'h1)
    `CHK(inmi, n)
    `CHK(iret, pc_e)
  endtask

  function automatic word_t rel(input logic [4:0] imm, input logic [11:0] m, input logic [4:0] r);
    return {m[11:1], r, 10'h019, imm, m[0]};
  endfunction

  task automatic do_cmp(input logic [4:0] r2, input logic [4:0] r1, input logic imm);
    word_t a, b, d;
    a = imm ? {{27{r1[4]}}, r1} : regs[r1];
    b = regs[r2];
    d = b - a;
    psw_e[3] = b < a;
    psw_e[2] = (a[31] != b[31]) && (d[31] != b[31]);
    psw_e[1] = d[31];
    psw_e[0] = d == 32'h0;
    issue({16'h0, r2, imm ? 6'h13 : 6'h0F, r1}, 1'h1);
    pc_e += 32'h2;
    chk_reg(8'h00, {24'h0, psw_e});
    chk_gpr(r2);
    chk_pc();
  endtask

  task automatic do_div(input logic [4:0] r1, input logic [4:0] r2, input logic [4:0] r3);
    word_t a, b, q;
    a = regs[r2];
    b = regs[r1];
    psw_e[2] = (b == 32'h0) || (a == 32'h80000000 && b == 32'hFFFFFFFF);
    q = (b == 32'h0) ? 32'h0 : psw_e[2] ? a : word_t'($signed(a) / $signed(b));
    regs[r2] = q;
    regs[r3] = (b == 32'h0) ? a : psw_e[2] ? 32'h0 : word_t'($signed(a) % $signed(b));
    // Flags follow the quotient even when the remainder overwrites it
    psw_e[1] = q[31];
    psw_e[0] = q == 32'h0;
    issue({r3, 11'h2C0, r2, 6'h3F, r1}, 1'h1);
    pc_e += 32'h4;
    chk_gpr(r2);
    chk_gpr(r3);
    chk_gpr(r1);
    chk_reg(8'h00, {24'h0, psw_e});
    chk_pc();
  endtask

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    summarize();
  end

  initial begin
    arst_n = 1'h0;
    instr = 32'h0;
    ivalid = 1'h0;
    tsave = 1'h0;
    irq = 1'h0;
    nmi = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lat = 3'h1;
    fail_count = 0;
    checks_done = 0;
    for (int k = 0; k < 64; k++) mem.words[k] = (k < 12) ? INIT[k] : 32'hA5000000 | k;
    foreach (regs[k]) regs[k] = 32'h0;
    psw_e = 8'h20;
    pc_e = 32'h0;
    repeat (5) @(posedge clock);
    arst_n <= 1'h1;
    @(posedge clock);
    chk_reg(8'h00, 32'h20);
    apb(1'h0, 8'h18, 32'h0);
    `CHK(err, 1'h1)
    `CHK(rd, 32'h0)
    // General registers are only reachable by pops, so loading them is the first instruction test after the reset checks
    issue(rel(5'h0, 12'hFFF, 5'h0), 1'h1);
    for (int k = 0; k < 12; k++) regs[31 - k] = INIT[k];
    regs[3] = 32'h30;
    pc_e = 32'h4;
    for (int n = 20; n < 32; n++) chk_gpr(5'(n));
    chk_gpr(5'h03);
    chk_pc();
    apb(1'h1, 8'h00, 32'h30);
    psw_e = 8'h30;
    do_cmp(5'h1F, 5'h1E, 1'h0);
    do_cmp(5'h14, 5'h15, 1'h0);
    do_cmp(5'h1F, 5'h1C, 1'h0);
    do_cmp(5'h16, 5'h10, 1'h1);
    do_cmp(5'h1C, 5'h07, 1'h1);
    apb(1'h1, 8'h00, 32'h38);
    psw_e = 8'h38;
    do_div(5'h1B, 5'h1C, 5'h17);
    do_div(5'h16, 5'h14, 5'h14);
    do_div(5'h1E, 5'h1F, 5'h16);
    do_div(5'h1D, 5'h19, 5'h15);
    issue({5'h17, 11'h2C0, 5'h1C, 6'h3F, 5'h1B}, 1'h0);
    repeat (3) @(posedge clock);
    nmi <= 1'h1;
    wait_take(1'h1);
    nmi <= 1'h0;
    wait_ready();
    chk_gpr(5'h1C);
    chk_gpr(5'h17);
    chk_pc();
    issue(rel(5'h1, 12'hFFF, 5'h0), 1'h0);
    nmi <= 1'h1;
    wait_take(1'h1);
    nmi <= 1'h0;
    wait_ready();
    chk_gpr(5'h03);
    chk_gpr(5'h1F);
    // Remainder 0xE lands in the stack pointer, so the next pops start misaligned
    do_div(5'h18, 5'h03, 5'h03);
    lat <= 3'h3;
    issue(rel(5'h1, 12'h005, 5'h18), 1'h1);
    regs[30] = 32'hFFFFFFFE;
    regs[29] = 32'h80000000;
    regs[3] = 32'h1A;
    pc_e = regs[24] & 32'hFFFFFFFE;
    chk_gpr(5'h1E);
    chk_gpr(5'h1D);
    chk_gpr(5'h03);
    chk_pc();
    issue(32'h0000F840, 1'h1);
    chk_reg(8'h10, pc_e + 32'h2);
    chk_reg(8'h14, {24'h0, psw_e});
    chk_reg(8'h00, {24'h0, psw_e | 8'hE0});
    @(negedge clock);
    `CHK(pc, 32'h60)
    `CHK(dbg, 1'h1)
    @(posedge clock);
    issue(32'h014607E0, 1'h1);
    pc_e += 32'h2;
    chk_reg(8'h00, {24'h0, psw_e});
    @(negedge clock);
    `CHK(dbg, 1'h0)
    @(posedge clock);
    chk_pc();
    tsave <= 1'h1;
    @(posedge clock);
    tsave <= 1'h0;
    tc_pc = pc_e + 32'h2;
    tc_psw = psw_e;
    chk_reg(8'h08, tc_pc);
    chk_reg(8'h0C, {24'h0, tc_psw});
    apb(1'h1, 8'h00, 32'h0);
    irq <= 1'h1;
    wait_take(1'h0);
    irq <= 1'h0;
    wait_ready();
    issue(32'h016007E0, 1'h0);
    irq <= 1'h1;
    pc_e += 32'h4;
    err = 1'h0;
    repeat (4) begin
      @(negedge clock);
      err |= (itake !== 1'h0);
      @(posedge clock);
    end
    `CHK(err, 1'h0)
    chk_reg(8'h00, 32'h20);
    nmi <= 1'h1;
    wait_take(1'h1);
    nmi <= 1'h0;
    irq <= 1'h0;
    wait_ready();
    issue(32'h014407E0, 1'h1);
    pc_e = tc_pc;
    chk_pc();
    chk_reg(8'h00, {24'h0, tc_psw});
    // A word outside the handled set is flagged and leaves the counter alone
    issue(32'h0, 1'h0);
    @(negedge clock);
    `CHK(unk, 1'h1)
    `CHK(pc, pc_e)
    @(posedge clock);
    summarize();
  end
endmodule
`default_nettype wire

// ### dv/stack_mem_model.sv
// Stack data memory that answers the pop loads of a frame release
`default_nettype none
module stack_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire exec_pkg::word_t addr,
  input wire logic [2:0] lat,
  output exec_pkg::word_t rdata,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  word_t words [0:63];
  logic [2:0] wait_q;
  word_t last_q;
  // Zero wait cycles answers in the cycle of the request
  assign ack = req && (wait_q == lat);
  // Off the answer the lines show the inverse of the last word, so stale data never matches
  assign rdata = ack ? words[addr[7:2]] : ~last_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 3'h0;
    end else if (!req || ack) begin
      wait_q <= 3'h0;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_q <= 32'h0;
    end else if (ack) begin
      last_q <= rdata;
    end
  end
endmodule
`default_nettype wire

// ### rtl/exec_cfg.svh
// Constants for the compare, return, trap, divide and frame-release execution unit
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// Opcode fields
`define OPF_CMP_REG 6'h0F
`define OPF_CMP_IMM 6'h13
`define OPF_EXT 6'h3F
`define LO_DBG_BREAK 16'hF840
`define LO_SYS 16'h07E0
`define HI_TC_RESUME 16'h0144
`define HI_DBG_RESUME 16'h0146
`define HI_IRQ_BLOCK 16'h0160
`define HI_SDIV 11'h2C0
`define LO_FRAME_REL 10'h019

// Program status word bit positions
`define PSW_Z 0
`define PSW_S 1
`define PSW_OV 2
`define PSW_CY 3
`define PSW_SAT 4
`define PSW_ID 5
`define PSW_EP 6
`define PSW_NP 7
`define PSW_RESET 8'h20

// Addresses and sizes
`define RESET_PC 32'h00000000
`define DBG_HANDLER 32'h00000060
`define LEN_SHORT 32'h00000002
`define LEN_LONG 32'h00000004
`define POP_STEP 32'h00000004
`define WORD_MIN 32'h80000000
`define WORD_ONES 32'hFFFFFFFF
`define SP_REG 5'h03
`define POP_BASE_REG 5'h14
`define POP_COUNT 12
// List bit for r31 down to r20, five bits each, r20 in the low slot
`define POP_BIT_POS {5'h15, 5'h00, 5'h16, 5'h17, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h18, 5'h19, 5'h1A, 5'h1B}
`define DIV_CYCLES 4'h8

// Register map, byte addresses
`define OFS_PSW 8'h00
`define OFS_PC 8'h04
`define OFS_TC_PC 8'h08
`define OFS_TC_PSW 8'h0C
`define OFS_DBG_PC 8'h10
`define OFS_DBG_PSW 8'h14
`define GPR_WIN_BIT 7

`endif

// ### rtl/exec_pkg.sv
// Types shared by the execution unit
`default_nettype none
package exec_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] psw_t;
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_SPADJ, S_POP} state_t;
endpackage
`default_nettype wire

// ### rtl/exec_unit.sv
// Execution unit for compare, returns, debug trap, irq block, frame release and divide
`include "exec_cfg.svh"
`default_nettype none

// How it works
// - Register compare subtracts, sets flags, no writes
// - Immediate compare uses sign-extended five-bit literal
// - Compare sets carry, overflow, sign, zero; keeps sticky
// - Table-call resume restores counter and whole status
// - Debug resume restores counter, status, leaves debug
// - Debug break saves state, sets three flags, jumps
// - Debug break leaves other status flags alone
// - Irq block sets the maskable block flag
// - No interrupt sampling during irq block itself
// - Non-maskable interrupts still accepted after block
// - Frame release adds scaled literal, pops words
// - Pop mask bit mapping to r20..r31
// - Pops run from r31 downward to r20
// - Jump form goes to source register, bit0 cleared
// - Pop addresses have low two bits forced zero
// - Interrupt before stack update aborts, restarts instruction
// - Signed divide writes quotient and remainder
// - Overflow on min by minus one or zero
// - Interrupt during divide aborts, keeps sources
// - Same destination keeps the remainder
// - Table call saves next address and status
module exec_unit (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire exec_pkg::word_t INSTR,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  output logic INSTR_UNKNOWN,
  input wire logic TCALL_SAVE,
  input wire logic IRQ_REQ,
  input wire logic NMI_REQ,
  output logic INT_TAKE,
  output logic INT_NMI,
  output exec_pkg::word_t INT_RET_PC,
  output logic DEBUG_MODE,
  output exec_pkg::word_t PC,
  output logic MEM_REQ,
  output exec_pkg::word_t MEM_ADDR,
  input wire exec_pkg::word_t MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire exec_pkg::word_t PWDATA,
  output exec_pkg::word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import exec_pkg::*;

  localparam logic [59:0] POP_POS = `POP_BIT_POS;
  state_t st_q;
  word_t gpr_q [32];
  word_t pc_q, tc_pc_q, dbg_pc_q, int_pc_q, prdata_q;
  psw_t psw_q, tc_psw_q, dbg_psw_q;
  logic dbg_q, int_take_q, int_nmi_q, unknown_q;
  logic [3:0] cnt_q;
  logic [11:0] pend_q;
  logic [4:0] imm_q, jreg_q, dvd_q, dvs_q, rdst_q;
  logic [15:0] lo, hi;
  logic is_cmp, is_cmpi, is_dbrk, is_tcr, is_dbr, is_blk, is_div, is_rel, is_known;
  logic int_req, go, int_idle, div_abort, div_done, sp_abort, pop_fire, pop_end;
  logic [11:0] list_sel;
  logic [3:0] top;
  word_t a2, sub, dvd, dvs, quot, rem, sp;
  logic [32:0] diff;
  logic cmp_ov, div_zero, div_ovf;
  assign lo = INSTR[15:0];
  assign hi = INSTR[31:16];
  assign is_cmp = lo[10:5] == `OPF_CMP_REG;
  assign is_cmpi = lo[10:5] == `OPF_CMP_IMM;
  assign is_dbrk = lo == `LO_DBG_BREAK;
  assign is_tcr = lo == `LO_SYS && hi == `HI_TC_RESUME;
  assign is_dbr = lo == `LO_SYS && hi == `HI_DBG_RESUME;
  assign is_blk = lo == `LO_SYS && hi == `HI_IRQ_BLOCK;
  assign is_div = lo[10:5] == `OPF_EXT && hi[10:0] == `HI_SDIV && !is_tcr && !is_dbr && !is_blk;
  assign is_rel = lo[15:6] == `LO_FRAME_REL;
  assign is_known = is_cmp | is_cmpi | is_dbrk | is_tcr | is_dbr | is_blk | is_div | is_rel;
  // Non-maskable requests ignore the block flag
  assign int_req = NMI_REQ | (IRQ_REQ & ~psw_q[`PSW_ID]);
  // Interrupts are only sampled between instructions or at the abort points
  assign int_idle = CE && st_q == S_IDLE && int_req;
  assign go = CE && st_q == S_IDLE && INSTR_VALID && !int_req;
  assign div_abort = CE && st_q == S_DIV && int_req;
  assign div_done = CE && st_q == S_DIV && !int_req && cnt_q == 4'h0;
  assign sp_abort = CE && st_q == S_SPADJ && int_req;
  assign pop_fire = CE && st_q == S_POP && pend_q != 12'h000 && MEM_ACK;
  assign pop_end = CE && st_q == S_POP && pend_q == 12'h000;
  assign INSTR_READY = st_q == S_IDLE && !int_req;
  assign MEM_REQ = st_q == S_POP && pend_q != 12'h000;
  assign MEM_ADDR = {sp[31:2], 2'b00};
  assign PC = pc_q;
  assign DEBUG_MODE = dbg_q;
  assign INT_TAKE = int_take_q;
  assign INT_NMI = int_nmi_q;
  assign INT_RET_PC = int_pc_q;
  assign INSTR_UNKNOWN = unknown_q;
  assign sp = gpr_q[`SP_REG];
  // Pop mask bits that name r20+k
  for (genvar k = 0; k < `POP_COUNT; k++) begin : g_list
    assign list_sel[k] = INSTR[POP_POS[k*5 +: 5]];
  end

  // Highest pending register pops first
  always_comb begin
    top = 4'h0;
    for (int k = 0; k < `POP_COUNT; k++) begin
      if (pend_q[k]) begin
        top = 4'(k);
      end
    end
  end
  // Compare datapath
  always_comb begin
    a2 = gpr_q[lo[15:11]];
    sub = is_cmpi ? {{27{lo[4]}}, lo[4:0]} : gpr_q[lo[4:0]];
    diff = {1'b0, a2} - {1'b0, sub};
    cmp_ov = (a2[31] != sub[31]) && (diff[31] != a2[31]);
  end

  // Divide result; operands are only read at the end so an abort changes nothing
  always_comb begin
    dvd = gpr_q[dvd_q];
    dvs = gpr_q[dvs_q];
    div_zero = dvs == 32'h00000000;
    div_ovf = dvd == `WORD_MIN && dvs == `WORD_ONES;
    quot = div_zero ? 32'h0 : div_ovf ? dvd : 32'($signed(dvd) / $signed(dvs));
    rem = div_zero ? dvd : div_ovf ? 32'h0 : 32'($signed(dvd) % $signed(dvs));
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
    end else if (CE) begin
      case (st_q)
        S_IDLE: begin
          if (go && is_div) begin
            st_q <= S_DIV;
            cnt_q <= `DIV_CYCLES - 4'h1;
          end else if (go && is_rel) begin
            st_q <= S_SPADJ;
          end
        end
        S_DIV: begin
          if (int_req || cnt_q == 4'h0) begin
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_SPADJ: st_q <= int_req ? S_IDLE : S_POP;
        S_POP: st_q <= pend_q == 12'h000 ? S_IDLE : S_POP;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Operand fields held for the multi-cycle instructions
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_q <= 12'h000;
      imm_q <= 5'h00;
      jreg_q <= 5'h00;
      dvd_q <= 5'h00;
      dvs_q <= 5'h00;
      rdst_q <= 5'h00;
    end else if (CE) begin
      if (go && is_rel) begin
        pend_q <= list_sel;
        imm_q <= lo[5:1];
        jreg_q <= hi[4:0];
      end else if (pop_fire) begin
        pend_q <= pend_q & ~(12'h001 << top);
      end
      if (go && is_div) begin
        dvd_q <= lo[15:11];
        dvs_q <= lo[4:0];
        rdst_q <= hi[15:11];
      end
    end
  end

  // General registers; r0 reads as zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= 32'h00000000;
      end
    end else if (CE) begin
      if (div_done) begin
        gpr_q[dvd_q] <= quot;
        gpr_q[rdst_q] <= rem;
      end
      if (st_q == S_SPADJ && !int_req) begin
        gpr_q[`SP_REG] <= sp + {25'h0000000, imm_q, 2'b00};
      end
      if (pop_fire) begin
        gpr_q[`POP_BASE_REG + 5'(top)] <= MEM_RDATA;
        gpr_q[`SP_REG] <= sp + `POP_STEP;
      end
      gpr_q[0] <= 32'h00000000;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_q <= `RESET_PC;
    end else if (CE) begin
      if (go) begin
        if (is_cmp || is_cmpi) begin
          pc_q <= pc_q + `LEN_SHORT;
        end else if (is_dbrk) begin
          pc_q <= `DBG_HANDLER;
        end else if (is_tcr) begin
          pc_q <= tc_pc_q;
        end else if (is_dbr) begin
          pc_q <= dbg_pc_q;
        end else if (is_blk) begin
          pc_q <= pc_q + `LEN_LONG;
        end
      end else if (div_done) begin
        pc_q <= pc_q + `LEN_LONG;
      end else if (pop_end) begin
        pc_q <= jreg_q != 5'h00 ? {gpr_q[jreg_q][31:1], 1'b0} : pc_q + `LEN_LONG;
      end
    end
  end

  // Hardware updates win over a software write in the same cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      psw_q <= `PSW_RESET;
    end else if (CE) begin
      if (go && (is_cmp || is_cmpi)) begin
        psw_q[`PSW_CY] <= diff[32];
        psw_q[`PSW_OV] <= cmp_ov;
        psw_q[`PSW_S] <= diff[31];
        psw_q[`PSW_Z] <= diff[31:0] == 32'h00000000;
      end else if (go && is_tcr) begin
        psw_q <= tc_psw_q;
      end else if (go && is_dbr) begin
        psw_q <= dbg_psw_q;
      end else if (go && is_dbrk) begin
        psw_q[`PSW_NP] <= 1'b1;
        psw_q[`PSW_EP] <= 1'b1;
        psw_q[`PSW_ID] <= 1'b1;
      end else if (go && is_blk) begin
        psw_q[`PSW_ID] <= 1'b1;
      end else if (div_done) begin
        psw_q[`PSW_OV] <= div_zero | div_ovf;
        psw_q[`PSW_S] <= quot[31];
        psw_q[`PSW_Z] <= quot == 32'h00000000;
      end else if (PSEL && PENABLE && PWRITE && PADDR == `OFS_PSW) begin
        psw_q <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tc_pc_q <= `RESET_PC;
      tc_psw_q <= `PSW_RESET;
    end else if (CE) begin
      if (TCALL_SAVE) begin
        tc_pc_q <= pc_q + `LEN_SHORT;
        tc_psw_q <= psw_q;
      end else if (PSEL && PENABLE && PWRITE) begin
        if (PADDR == `OFS_TC_PC) begin
          tc_pc_q <= PWDATA;
        end
        if (PADDR == `OFS_TC_PSW) begin
          tc_psw_q <= PWDATA[7:0];
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      dbg_pc_q <= `RESET_PC;
      dbg_psw_q <= `PSW_RESET;
      dbg_q <= 1'b0;
    end else if (CE) begin
      if (go && is_dbrk) begin
        dbg_pc_q <= pc_q + `LEN_SHORT;
        dbg_psw_q <= psw_q;
        dbg_q <= 1'b1;
      end else begin
        if (go && is_dbr) begin
          dbg_q <= 1'b0;
        end
        if (PSEL && PENABLE && PWRITE && PADDR == `OFS_DBG_PC) begin
          dbg_pc_q <= PWDATA;
        end
        if (PSEL && PENABLE && PWRITE && PADDR == `OFS_DBG_PSW) begin
          dbg_psw_q <= PWDATA[7:0];
        end
      end
    end
  end

  // Return address is the start of an aborted instruction, so it restarts
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_take_q <= 1'b0;
      int_nmi_q <= 1'b0;
      int_pc_q <= `RESET_PC;
      unknown_q <= 1'b0;
    end else if (CE) begin
      int_take_q <= int_idle | div_abort | sp_abort;
      unknown_q <= go && !is_known;
      if (int_idle || div_abort || sp_abort) begin
        int_nmi_q <= NMI_REQ;
        int_pc_q <= pc_q;
      end
    end
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q <= 32'h00000000;
    end else if (CE && PSEL && !PENABLE) begin
      if (PADDR[`GPR_WIN_BIT]) begin
        prdata_q <= gpr_q[PADDR[6:2]];
      end else begin
        case (PADDR)
          `OFS_PSW: prdata_q <= {24'h000000, psw_q};
          `OFS_PC: prdata_q <= pc_q;
          `OFS_TC_PC: prdata_q <= tc_pc_q;
          `OFS_TC_PSW: prdata_q <= {24'h000000, tc_psw_q};
          `OFS_DBG_PC: prdata_q <= dbg_pc_q;
          `OFS_DBG_PSW: prdata_q <= {24'h000000, dbg_psw_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  // Unmapped or misaligned addresses, and writes to read-only words, are errors
  assign PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'b00 ||
    (PADDR[`GPR_WIN_BIT] ? PWRITE :
     (PADDR > `OFS_DBG_PSW || (PWRITE && PADDR == `OFS_PC))));

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  cmp_zero_flag_a: assert property (go && (is_cmp || is_cmpi) |=>
    psw_q[`PSW_Z] == ($past(diff[31:0]) == 32'h00000000) && psw_q[`PSW_CY] == $past(diff[32]))
    else $error("compare flags wrong");
  cmp_sticky_keep_a: assert property (go && (is_cmp || is_cmpi) |=> $stable(psw_q[`PSW_SAT]))
    else $error("compare changed sticky flag");
  tc_resume_a: assert property (go && is_tcr |=>
    pc_q == $past(tc_pc_q) && psw_q == $past(tc_psw_q))
    else $error("table-call resume not restored");
  dbg_resume_a: assert property (go && is_dbr |=> !dbg_q && pc_q == $past(dbg_pc_q))
    else $error("debug resume wrong");
  dbg_break_a: assert property (go && is_dbrk |=> pc_q == `DBG_HANDLER &&
    dbg_pc_q == $past(pc_q) + `LEN_SHORT && psw_q[7:5] == 3'h7)
    else $error("debug break wrong");
  dbg_flags_keep_a: assert property (go && is_dbrk |=> psw_q[4:0] == $past(psw_q[4:0]))
    else $error("debug break touched other flags");
  irq_block_a: assert property (go && is_blk ##1 (CE && !NMI_REQ) |-> !int_idle)
    else $error("maskable interrupt slipped past block");
  nmi_accept_a: assert property (CE && st_q == S_IDLE && NMI_REQ |=> int_take_q && int_nmi_q)
    else $error("non-maskable request not taken");
  pop_order_a: assert property (pop_fire |=> (pend_q >> $past(top)) == 12'h000)
    else $error("pop order not descending");
  sp_abort_a: assert property (sp_abort |=>
    gpr_q[`SP_REG] == $past(sp) && int_pc_q == $past(pc_q) && st_q == S_IDLE)
    else $error("aborted release changed stack");
  div_flag_a: assert property (div_done |=> psw_q[`PSW_OV] == $past(div_zero | div_ovf))
    else $error("divide overflow flag wrong");
  div_abort_a: assert property (div_abort |=> st_q == S_IDLE && int_pc_q == $past(pc_q)
    && pc_q == $past(pc_q))
    else $error("divide abort not clean");
  div_rem_wins_a: assert property (div_done && dvd_q == rdst_q && rdst_q != 5'h00 |=>
    gpr_q[$past(rdst_q)] == $past(rem))
    else $error("remainder not kept");

  release_jump_c: cover property (pop_end && jreg_q != 5'h00);
  div_done_c: cover property (div_done && div_ovf);
  div_abort_c: cover property (div_abort);
  dbg_round_c: cover property (go && is_dbrk ##[1:20] go && is_dbr);
endmodule
`default_nettype wire
